/* hdl/simd_dp_defs.vh */
`ifndef SIMD_DP_DEFS_VH
`define SIMD_DP_DEFS_VH
// Function
// RL1: accept a line of one to four 32-bit slots, one line per cycle.
// RL2: slots execute in parallel as encoded, never reordered; later slot wins; code lets a compute result overwrite a load of the same line.
// RL3: results take two cycles; dependent lines stall automatically until ready.
// RL4: dual-block slots broadcast identical data or merge separate data per slot.
// RL5: packed adds over four 16-bit or eight 8-bit lanes per word pair.
// RL6: each block takes up to two compute slots per line on separate units.
// RL7: two full blocks, X and Y, chosen by a block field in the slot.
// RL8: 32-word register file read and written as words, pairs or quads.
// RL9: ALU does fixed and floating arithmetic plus logic operations.
// RL10: float operands 32 and 40 bits; fixed 8, 16, 32, 64 bits.
// RL11: multiplier does fixed and float multiply and fixed multiply-accumulate.
// RL12: 64-bit shifter: logical, arithmetic shifts, field extract and deposit.
// RL13: each block has a 128-bit trellis and complex correlation unit.
// RL14: both accelerators together finish eight trellis butterflies per cycle.
// RL15: both blocks together finish two complex 16-bit MACs per cycle.
// RL16: loads without the buffer must be aligned to their data size.
// RL17: a FIFO of quad lines lets quad loads use unaligned addresses.
// RL18: buffer merges consecutive lines, stalls until both covering lines are held.

// slot fields
`define SL_OP    31:27
`define SL_BLK   26:25
`define SL_SZ    24:23
`define SL_DST   22:18
`define SL_SRCA  17:13
`define SL_SRCB  12:8
`define SL_BUF   7

// block selector
`define BLK_X    2'h0
`define BLK_Y    2'h1
`define BLK_BC   2'h2
`define BLK_MRG  2'h3

// access size
`define SZ_WORD  2'h0
`define SZ_DUAL  2'h1
`define SZ_QUAD  2'h2

// float sign positions
`define F32_SIGN 32'h80000000
`define F40_SIGN 40'h8000000000

// operations
`define OP_NOP   5'h00
`define OP_ADD32 5'h01
`define OP_SUB32 5'h02
`define OP_ADD16 5'h03
`define OP_ADD8  5'h04
`define OP_ADD64 5'h05
`define OP_AND   5'h06
`define OP_OR    5'h07
`define OP_XOR   5'h08
`define OP_MUL   5'h09
`define OP_MAC   5'h0a
`define OP_SHL   5'h0b
`define OP_LSR   5'h0c
`define OP_ASR   5'h0d
`define OP_FEXT  5'h0e
`define OP_FDEP  5'h0f
`define OP_FMUL  5'h10
`define OP_FNEG  5'h11
`define OP_FABS  5'h12
`define OP_ACS   5'h13
`define OP_CMAC  5'h14
`define OP_LOAD  5'h15
`endif

/* hdl/simd_exec_unit.v */
`timescale 1ns/100ps
`include "simd_dp_defs.vh"

module simd_exec_unit
(
	// operation
	input  wire [4:0]   op,
	input  wire [1:0]   size,
	// operands, c is the old destination
	input  wire [127:0] opA,
	input  wire [127:0] opB,
	input  wire [127:0] opC,
	// result
	output reg  [127:0] res
);

	wire        [127:0] add32;
	wire        [127:0] sub32;
	wire        [127:0] add16;
	wire        [127:0] add8;
	wire        [127:0] acs;
	wire signed [63:0]  prod;
	wire signed [31:0]  cre;
	wire signed [31:0]  cim;
	wire        [63:0]  fmask;
	wire        [5:0]   pos;
	wire        [127:0] sgn;

	function [15:0] smax;
		input [15:0] x;
		input [15:0] y;
		smax = ($signed(x) > $signed(y)) ? x : y;
	endfunction

	// no denormals, truncating; underflow flushes to signed zero
	function [31:0] fmul;
		input [31:0] x;
		input [31:0] y;
		reg   [47:0] m;
		reg   [9:0]  e;
		begin
			m = {1'b1, x[22:0]} * {1'b1, y[22:0]};
			e = {2'h0, x[30:23]} + {2'h0, y[30:23]} - 10'h07f + {9'h000, m[47]};
			if (x[30:23] == 8'h00 || y[30:23] == 8'h00 || e[9])
				fmul = {x[31] ^ y[31], 31'h00000000};
			else if (e[8] || e[7:0] == 8'hff)
				fmul = {x[31] ^ y[31], 8'hff, 23'h000000};
			else
				fmul = {x[31] ^ y[31], e[7:0], m[47] ? m[46:24] : m[45:23]};
		end
	endfunction

	genvar i;
	generate
		for (i = 0; i < 4; i = i + 1)
		begin : gWord
			assign add32[i*32 +: 32] = opA[i*32 +: 32] + opB[i*32 +: 32];
			assign sub32[i*32 +: 32] = opA[i*32 +: 32] - opB[i*32 +: 32];
			// one butterfly per word: two path metrics against one branch metric
			assign acs[i*32 +: 16] = smax(opA[i*32 +: 16] + opB[i*32 +: 16],
				opA[i*32+16 +: 16] - opB[i*32 +: 16]); // RL13 RL14
			assign acs[i*32+16 +: 16] = smax(opA[i*32 +: 16] - opB[i*32 +: 16],
				opA[i*32+16 +: 16] + opB[i*32 +: 16]); // RL14
		end
		for (i = 0; i < 8; i = i + 1)
		begin : gHalf
			assign add16[i*16 +: 16] = opA[i*16 +: 16] + opB[i*16 +: 16]; // RL5
		end
		for (i = 0; i < 16; i = i + 1)
		begin : gByte
			assign add8[i*8 +: 8] = opA[i*8 +: 8] + opB[i*8 +: 8]; // RL5
		end
	endgenerate

	assign prod  = $signed(opA[31:0]) * $signed(opB[31:0]);
	assign cre   = $signed(opA[15:0]) * $signed(opB[15:0])
		- $signed(opA[31:16]) * $signed(opB[31:16]);
	assign cim   = $signed(opA[15:0]) * $signed(opB[31:16])
		+ $signed(opA[31:16]) * $signed(opB[15:0]);
	assign pos   = opB[5:0];
	assign fmask = ~(64'hffffffffffffffff << opB[14:8]);
	// word size means four 32-bit floats, otherwise one 40-bit float in a pair
	assign sgn   = (size == `SZ_WORD) ? {4{`F32_SIGN}} : {88'h0, `F40_SIGN}; // RL10

	always @*
	begin
		case (op)
			`OP_ADD32: res = add32; // RL9
			`OP_SUB32: res = sub32;
			`OP_ADD16: res = add16;
			`OP_ADD8:  res = add8;
			`OP_ADD64: res = {64'h0, opA[63:0] + opB[63:0]}; // RL10
			`OP_AND:   res = opA & opB;
			`OP_OR:    res = opA | opB;
			`OP_XOR:   res = opA ^ opB;
			`OP_MUL:   res = {64'h0, prod}; // RL11
			`OP_MAC:   res = {64'h0, opC[63:0] + prod}; // RL11
			`OP_SHL:   res = {64'h0, opA[63:0] << pos}; // RL12
			`OP_LSR:   res = {64'h0, opA[63:0] >> pos};
			`OP_ASR:   res = {64'h0, $signed(opA[63:0]) >>> pos};
			`OP_FEXT:  res = {64'h0, (opA[63:0] >> pos) & fmask};
			`OP_FDEP:  res = {64'h0, (opC[63:0] & ~(fmask << pos)) | ((opA[63:0] & fmask) << pos)};
			`OP_FMUL:  res = {fmul(opA[127:96], opB[127:96]), fmul(opA[95:64], opB[95:64]),
				fmul(opA[63:32], opB[63:32]), fmul(opA[31:0], opB[31:0])}; // RL11
			`OP_FNEG:  res = opA ^ sgn; // RL9
			`OP_FABS:  res = opA & ~sgn;
			`OP_ACS:   res = acs;
			`OP_CMAC:  res = {64'h0, opC[63:32] + cim, opC[31:0] + cre}; // RL15
			default:   res = 128'h0;
		endcase
	end

endmodule // simd_exec_unit

/* hdl/dual_simd_compute_datapath.v */
`timescale 1ns/100ps
`include "simd_dp_defs.vh"

module dual_simd_compute_datapath
#(
	parameter BUF_DEPTH = 2
)
(
	// clock and reset
	input  wire         core_clk,
	input  wire         srst,
	// instruction line from the sequencer
	input  wire         lineValid,
	input  wire [3:0]   slotValid,
	input  wire [127:0] lineSlots,
	input  wire [31:0]  ldAddr,
	output wire         lineReady,
	output wire         badLine,
	// aligned quad reads on the data bus
	output wire         rdReq,
	output wire [29:0]  rdAddr,
	input  wire         rdValid,
	input  wire [127:0] rdData,
	// register reads for stores on the data bus
	input  wire         stReq,
	input  wire         stBlk,
	input  wire [4:0]   stIdx,
	input  wire [1:0]   stSize,
	output wire         stValid,
	output wire [127:0] stData
);

	localparam PW      = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
	localparam LD_IDLE = 1'b0;
	localparam LD_WAIT = 1'b1;

	// -------------------------------------------------------------
	// state
	// -------------------------------------------------------------
	reg  [2047:0] rf_ff;
	reg  [2047:0] nxt_rf;
	reg  [3:0]    e1Vld_ff;
	reg  [19:0]   e1Dst_ff;
	reg  [7:0]    e1Sz_ff;
	reg  [511:0]  e1Res_ff;
	reg           ldState_ff;
	reg           rdReq_ff;
	reg  [29:0]   rdAddr_ff;
	reg           badLine_ff;
	reg           stValid_ff;
	reg  [127:0]  stData_ff;
	reg  [29:0]   bufTag_ff  [0:BUF_DEPTH-1];
	reg  [127:0]  bufData_ff [0:BUF_DEPTH-1];
	reg  [BUF_DEPTH-1:0] bufVld_ff;
	reg  [PW-1:0] bufPtr_ff;

	// -------------------------------------------------------------
	// decode and issue signals
	// -------------------------------------------------------------
	reg  [7:0]    uSlot;
	reg  [3:0]    uUse;
	reg  [19:0]   uOp;
	reg  [7:0]    uSz;
	reg  [7:0]    uWsz;
	reg  [19:0]   uDst;
	reg  [511:0]  uA;
	reg  [511:0]  uB;
	reg  [511:0]  uC;
	wire [511:0]  uRes;
	reg           over;
	reg           hazard;
	reg           ldHas;
	reg  [31:0]   ldSl;
	reg  [31:0]   dSl;
	reg  [31:0]   iSl;
	reg  [3:0]    cnt;
	integer       s;
	integer       b;
	integer       u;
	integer       p;
	integer       w;
	integer       k;

	// load path signals
	reg  [29:0]   q0;
	reg  [29:0]   q1;
	reg  [1:0]    ldSz;
	reg           ldBuf;
	reg           ldBad;
	reg           needHi;
	reg           hitLo;
	reg           hitHi;
	reg  [127:0]  loData;
	reg  [127:0]  hiData;
	reg           ldDone;
	reg           ldFetch;
	reg  [29:0]   fetchQ;
	reg  [255:0]  ldSh;
	reg  [127:0]  ldVal;
	wire          lineFire;

	// -------------------------------------------------------------
	// helpers
	// -------------------------------------------------------------
	function [4:0] alignIdx;
		input [4:0] idx;
		input [1:0] sz;
		alignIdx = (sz == `SZ_WORD) ? idx :
			(sz == `SZ_DUAL) ? {idx[4:1], 1'b0} : {idx[4:2], 2'b00};
	endfunction

	function [2:0] nWords;
		input [1:0] sz;
		nWords = (sz == `SZ_WORD) ? 3'h1 : (sz == `SZ_DUAL) ? 3'h2 : 3'h4;
	endfunction

	function hitsBlk;
		input [1:0] blk;
		input       bk;
		hitsBlk = blk[1] || (blk[0] == bk); // RL7
	endfunction

	function isComp;
		input [4:0] op;
		isComp = (op != `OP_NOP) && (op < `OP_LOAD);
	endfunction

	function readsC;
		input [4:0] op;
		readsC = (op == `OP_MAC) || (op == `OP_CMAC) || (op == `OP_FDEP);
	endfunction

	function [1:0] wrSz;
		input [4:0] op;
		input [1:0] sz;
		wrSz = (op == `OP_MUL || op == `OP_MAC || op == `OP_CMAC) ? `SZ_DUAL : sz;
	endfunction

	function ovl;
		input [4:0] a;
		input [1:0] sa;
		input [4:0] c;
		input [1:0] sc;
		reg   [5:0] a0;
		reg   [5:0] c0;
		begin
			a0 = {1'b0, alignIdx(a, sa)};
			c0 = {1'b0, alignIdx(c, sc)};
			ovl = (a0 < c0 + {3'h0, nWords(sc)}) && (c0 < a0 + {3'h0, nWords(sa)});
		end
	endfunction

	// unused upper words of a narrow read come back as zero
	// the file is passed in so that combinational callers see every register change
	function [127:0] rdReg;
		input [2047:0] r;
		input          bk;
		input [4:0]    idx;
		input [1:0]    sz;
		integer        j;
		reg   [5:0]    base;
		begin
			base = {bk, alignIdx(idx, sz)};
			rdReg = 128'h0;
			for (j = 0; j < 4; j = j + 1)
				if (j < nWords(sz))
					rdReg[j*32 +: 32] = r[(base + j)*32 +: 32]; // RL8
		end
	endfunction

	function [2047:0] wrReg;
		input [2047:0] r;
		input          bk;
		input [4:0]    idx;
		input [1:0]    sz;
		input [127:0]  d;
		integer        j;
		reg   [5:0]    base;
		begin
			base = {bk, alignIdx(idx, sz)};
			wrReg = r;
			for (j = 0; j < 4; j = j + 1)
				if (j < nWords(sz))
					wrReg[(base + j)*32 +: 32] = d[j*32 +: 32]; // RL8
		end
	endfunction

	// -------------------------------------------------------------
	// slot to unit assignment, operand read, interlock
	// -------------------------------------------------------------
	always @*
	begin
		uUse  = 4'h0;
		uSlot = 8'h00;
		cnt   = 4'h0;
		over  = 1'b0;
		ldHas = 1'b0;
		ldSl  = 32'h0;
		dSl   = 32'h0;
		// slots are walked in encoded order so the assignment is static
		for (s = 0; s < 4; s = s + 1)
		begin
			dSl = lineSlots[s*32 +: 32];
			if (slotValid[s] && isComp(dSl[`SL_OP])) // RL2
			begin
				for (b = 0; b < 2; b = b + 1)
					if (hitsBlk(dSl[`SL_BLK], b[0])) // RL4
					begin
						if (cnt[b*2 +: 2] < 2'h2) // RL6
						begin
							uSlot[(b*2 + cnt[b*2 +: 2])*2 +: 2] = s[1:0];
							uUse[b*2 + cnt[b*2 +: 2]] = 1'b1;
							cnt[b*2 +: 2] = cnt[b*2 +: 2] + 2'h1;
						end
						else
							over = 1'b1;
					end
			end
			else if (slotValid[s] && dSl[`SL_OP] == `OP_LOAD)
			begin
				if (ldHas)
					over = 1'b1;
				ldHas = 1'b1;
				ldSl  = dSl;
			end
			else if (slotValid[s] && dSl[`SL_OP] != `OP_NOP)
				over = 1'b1;
		end
	end

	always @*
	begin
		hazard = 1'b0;
		iSl    = 32'h0;
		uOp    = 20'h0;
		uSz    = 8'h00;
		uWsz   = 8'h00;
		uDst   = 20'h0;
		uA     = 512'h0;
		uB     = 512'h0;
		uC     = 512'h0;
		for (u = 0; u < 4; u = u + 1)
		begin
			iSl = lineSlots[uSlot[u*2 +: 2]*32 +: 32];
			uOp[u*5 +: 5]    = uUse[u] ? iSl[`SL_OP] : `OP_NOP;
			uSz[u*2 +: 2]    = iSl[`SL_SZ];
			uWsz[u*2 +: 2]   = wrSz(iSl[`SL_OP], iSl[`SL_SZ]);
			uDst[u*5 +: 5]   = iSl[`SL_DST];
			uA[u*128 +: 128] = rdReg(rf_ff, u[1], iSl[`SL_SRCA], iSl[`SL_SZ]);
			uB[u*128 +: 128] = rdReg(rf_ff, u[1], iSl[`SL_SRCB], iSl[`SL_SZ]);
			uC[u*128 +: 128] = rdReg(rf_ff, u[1], iSl[`SL_DST], uWsz[u*2 +: 2]);
			// a result still in the first stage is not in the file yet
			for (p = 0; p < 4; p = p + 1)
				if (uUse[u] && e1Vld_ff[p] && (p[1] == u[1]) &&
					(ovl(iSl[`SL_SRCA], iSl[`SL_SZ], e1Dst_ff[p*5 +: 5], e1Sz_ff[p*2 +: 2]) ||
					ovl(iSl[`SL_SRCB], iSl[`SL_SZ], e1Dst_ff[p*5 +: 5], e1Sz_ff[p*2 +: 2]) ||
					(readsC(iSl[`SL_OP]) && ovl(iSl[`SL_DST], uWsz[u*2 +: 2],
					e1Dst_ff[p*5 +: 5], e1Sz_ff[p*2 +: 2]))))
					hazard = 1'b1; // RL3
		end
	end

	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1)
		begin : gUnit
			simd_exec_unit u_exec
			(
				.op   (uOp[g*5 +: 5]),
				.size (uSz[g*2 +: 2]),
				.opA  (uA[g*128 +: 128]),
				.opB  (uB[g*128 +: 128]),
				.opC  (uC[g*128 +: 128]),
				.res  (uRes[g*128 +: 128])
			);
		end
	endgenerate

	// -------------------------------------------------------------
	// load path and unaligned load buffer
	// -------------------------------------------------------------
	always @*
	begin
		q0     = ldAddr[31:2];
		q1     = q0 + 30'h1;
		ldSz   = ldSl[`SL_SZ];
		ldBuf  = ldSl[`SL_BUF] && ldSz[1];
		ldBad  = ldHas && !ldBuf && ((ldSz == `SZ_DUAL && ldAddr[0]) ||
			(ldSz[1] && ldAddr[1:0] != 2'h0)); // RL16
		needHi = ldBuf && (ldAddr[1:0] != 2'h0);
		hitLo  = 1'b0;
		hitHi  = 1'b0;
		loData = 128'h0;
		hiData = 128'h0;
		for (w = 0; w < BUF_DEPTH; w = w + 1)
		begin
			if (bufVld_ff[w] && bufTag_ff[w] == q0)
			begin
				hitLo  = 1'b1;
				loData = bufData_ff[w];
			end
			if (bufVld_ff[w] && bufTag_ff[w] == q1)
			begin
				hitHi  = 1'b1;
				hiData = bufData_ff[w];
			end
		end
		if (!ldHas || ldBad)
			ldDone = 1'b1;
		else if (ldBuf)
			ldDone = (ldState_ff == LD_IDLE) && hitLo && (hitHi || !needHi); // RL18
		else
			ldDone = (ldState_ff == LD_WAIT) && rdValid;
		// a line left on the bus after it was taken must not fetch again
		ldFetch = lineValid && ldHas && !ldBad && !ldDone && !hazard &&
			(ldState_ff == LD_IDLE);
		fetchQ  = (!ldBuf || !hitLo) ? q0 : q1; // RL18
		ldSh    = (ldBuf ? {hiData, loData} : {128'h0, rdData}) >> {ldAddr[1:0], 5'h00}; // RL17
		ldVal   = ldSh[127:0];
	end

	assign lineReady = !hazard && ldDone; // RL3
	assign lineFire  = lineValid && lineReady; // RL1

	// -------------------------------------------------------------
	// register file write back
	// -------------------------------------------------------------
	always @*
	begin
		nxt_rf = rf_ff;
		// lower unit index retires first, so the later slot of a block wins
		for (k = 0; k < 4; k = k + 1)
			if (e1Vld_ff[k])
				nxt_rf = wrReg(nxt_rf, k[1], e1Dst_ff[k*5 +: 5], e1Sz_ff[k*2 +: 2],
					e1Res_ff[k*128 +: 128]); // RL2 RL3
		// the load belongs to a younger line than any retiring result
		if (lineFire && ldHas && !ldBad)
		begin
			if (ldSl[`SL_BLK] == `BLK_MRG && ldSz != `SZ_WORD)
			begin
				nxt_rf = wrReg(nxt_rf, 1'b0, ldSl[`SL_DST], ldSz[1] ? `SZ_DUAL : `SZ_WORD,
					{64'h0, ldVal[95:64], ldVal[31:0]}); // RL4
				nxt_rf = wrReg(nxt_rf, 1'b1, ldSl[`SL_DST], ldSz[1] ? `SZ_DUAL : `SZ_WORD,
					{64'h0, ldVal[127:96], ldVal[63:32]});
			end
			else
			begin
				if (hitsBlk(ldSl[`SL_BLK], 1'b0))
					nxt_rf = wrReg(nxt_rf, 1'b0, ldSl[`SL_DST], ldSz, ldVal); // RL4
				if (hitsBlk(ldSl[`SL_BLK], 1'b1))
					nxt_rf = wrReg(nxt_rf, 1'b1, ldSl[`SL_DST], ldSz, ldVal);
			end
		end
	end

	// -------------------------------------------------------------
	// clocked state
	// -------------------------------------------------------------
	always @(posedge core_clk)
	begin
		if (srst)
		begin
			rf_ff      <= 2048'h0;
			e1Vld_ff   <= 4'h0;
			e1Dst_ff   <= 20'h0;
			e1Sz_ff    <= 8'h00;
			e1Res_ff   <= 512'h0;
			ldState_ff <= LD_IDLE;
			rdReq_ff   <= 1'b0;
			rdAddr_ff  <= 30'h0;
			badLine_ff <= 1'b0;
			stValid_ff <= 1'b0;
			stData_ff  <= 128'h0;
			bufVld_ff  <= {BUF_DEPTH{1'b0}};
			bufPtr_ff  <= {PW{1'b0}};
		end
		else
		begin
			rf_ff      <= nxt_rf;
			e1Vld_ff   <= lineFire ? uUse : 4'h0; // RL1 RL6
			e1Dst_ff   <= uDst;
			e1Sz_ff    <= uWsz;
			e1Res_ff   <= uRes;
			badLine_ff <= lineFire && (over || ldBad); // RL16
			rdReq_ff   <= ldFetch;
			stValid_ff <= stReq;
			if (stReq)
				stData_ff <= rdReg(rf_ff, stBlk, stIdx, stSize); // RL8
			if (ldFetch)
				rdAddr_ff <= fetchQ;
			case (ldState_ff)
				LD_IDLE:
					if (ldFetch)
						ldState_ff <= LD_WAIT;
				LD_WAIT:
					if (rdValid)
						ldState_ff <= LD_IDLE;
				default:
					ldState_ff <= LD_IDLE;
			endcase
			// oldest line is overwritten, which suits a forward streaming walk
			if (ldState_ff == LD_WAIT && rdValid && ldBuf)
			begin
				bufVld_ff[bufPtr_ff] <= 1'b1; // RL17
				bufPtr_ff <= (bufPtr_ff == BUF_DEPTH - 1) ? {PW{1'b0}} : bufPtr_ff + 1'b1;
			end
		end
	end

	always @(posedge core_clk)
	begin
		if (ldState_ff == LD_WAIT && rdValid && ldBuf)
		begin
			bufTag_ff[bufPtr_ff]  <= rdAddr_ff;
			bufData_ff[bufPtr_ff] <= rdData;
		end
	end

	assign badLine = badLine_ff;
	assign rdReq   = rdReq_ff;
	assign rdAddr  = rdAddr_ff;
	assign stValid = stValid_ff;
	assign stData  = stData_ff;

endmodule // dual_simd_compute_datapath

/* verif/load_bus_model.sv */
`timescale 1ns/100ps

module load_bus_model
(
	// clock and reset
	input  logic         core_clk,
	input  logic         srst,
	// quad read requests from the datapath
	input  logic         rdReq,
	input  logic [29:0]  rdAddr,
	// answer delay in cycles, at least one
	input  logic [3:0]   lat,
	// read answer
	output logic         rdValid,
	output logic [127:0] rdData
);
	logic [29:0] qAddr_ff;
	logic [3:0]  cnt_ff;

	function automatic logic [31:0] memWord(input logic [31:0] a);
		return {a[15:0] ^ 16'h3c5a, a[15:0]};
	endfunction

	initial rdData = 128'h0;

	// data toggles outside the answer cycle so a stale capture shows up
	always @(posedge core_clk)
	begin
		rdValid <= 1'b0;
		rdData  <= ~rdData;
		if (srst)
			cnt_ff <= 4'h0;
		else if (rdReq)
		begin
			qAddr_ff <= rdAddr;
			cnt_ff   <= lat;
		end
		else if (cnt_ff != 4'h0)
		begin
			cnt_ff <= cnt_ff - 4'h1;
			if (cnt_ff == 4'h1)
			begin
				rdValid <= 1'b1;
				for (int k = 0; k < 4; k++)
					rdData[32*k +: 32] <= memWord({qAddr_ff, 2'h0} + k);
			end
		end
	end
endmodule // load_bus_model

/* verif/dual_simd_compute_datapath_asserts.sv */
`timescale 1ns/100ps
`include "simd_dp_defs.vh"

module dual_simd_compute_datapath_asserts
#(
	parameter BUF_DEPTH = 2
)
(
	// clock and reset
	input logic         core_clk,
	input logic         srst,
	// instruction line
	input logic         lineValid,
	input logic [3:0]   slotValid,
	input logic [127:0] lineSlots,
	input logic [31:0]  ldAddr,
	input logic         lineReady,
	input logic         badLine,
	// data bus reads
	input logic         rdReq,
	input logic [29:0]  rdAddr,
	input logic         rdValid,
	input logic [127:0] rdData,
	// register reads
	input logic         stReq,
	input logic         stBlk,
	input logic [4:0]   stIdx,
	input logic [1:0]   stSize,
	input logic         stValid,
	input logic [127:0] stData
);
	wire taken = lineValid && lineReady;
	wire addX0 = slotValid[0] && lineSlots[31:27] == `OP_ADD32 && lineSlots[26:25] == `BLK_X;
	wire ld0u  = slotValid[0] && lineSlots[31:27] == `OP_LOAD && !lineSlots[7] &&
		!(lineSlots[24] ? |ldAddr[1:0] : lineSlots[23] && ldAddr[0]);

	default clocking dc @(posedge core_clk); endclocking
	default disable iff (srst);

	sequence takenAdd;
		taken && addX0;
	endsequence
	sequence readsPrev;
		lineValid && addX0 && slotValid == 4'h1 && lineSlots[17:13] == $past(lineSlots[22:18]);
	endsequence

	chk_store_answer: assert property (stReq |=> stValid)
		else $error("register read not answered next cycle");
	chk_store_quiet: assert property (!stReq |=> !stValid)
		else $error("register read answer without request");
	chk_word_width: assert property (stReq && stSize == `SZ_WORD |=> stData[127:32] == 96'h0)
		else $error("word read has nonzero upper words");
	chk_dual_width: assert property (stReq && stSize == `SZ_DUAL |=> stData[127:64] == 64'h0)
		else $error("pair read has nonzero upper words");
	chk_bad_cause: assert property (badLine |-> $past(taken))
		else $error("bad line flag without a taken line");
	chk_fetch_pulse: assert property (rdReq |=> !rdReq)
		else $error("fetch request longer than one cycle");
	chk_fetch_wait: assert property (rdReq && lineValid |-> !lineReady)
		else $error("line taken while its fetch is outstanding");
	chk_aligned_data: assert property (taken && ld0u |-> rdValid)
		else $error("unbuffered load taken without read data");
	chk_dep_stall: assert property (takenAdd ##1 readsPrev |-> !lineReady)
		else $error("dependent line not stalled");
	chk_dep_release: assert property (takenAdd ##1 readsPrev ##1 lineValid |-> lineReady)
		else $error("dependent line stalled too long");
	chk_empty_go: assert property (lineValid && slotValid == 4'h0 |-> lineReady)
		else $error("empty line not accepted");
endmodule // dual_simd_compute_datapath_asserts

bind dual_simd_compute_datapath dual_simd_compute_datapath_asserts #(.BUF_DEPTH(BUF_DEPTH)) chk (
	.core_clk(core_clk), .srst(srst), .lineValid(lineValid), .slotValid(slotValid),
	.lineSlots(lineSlots), .ldAddr(ldAddr), .lineReady(lineReady), .badLine(badLine),
	.rdReq(rdReq), .rdAddr(rdAddr), .rdValid(rdValid), .rdData(rdData), .stReq(stReq),
	.stBlk(stBlk), .stIdx(stIdx), .stSize(stSize), .stValid(stValid), .stData(stData));

/* verif/dual_simd_compute_datapath_bench.sv */
`timescale 1ns/100ps
`include "simd_dp_defs.vh"
`define CHK(nm, ex, got) \
	checked++; \
	if ((ex) !== (got)) \
	begin \
		num_errors++; \
		$display("unexpected %s: expected %h seen %h", nm, ex, got); \
	end

module dual_simd_compute_datapath_bench;
	logic         core_clk, srst, lineValid, lineReady, badLine, rdReq, rdValid;
	logic         stReq, stBlk, stValid;
	logic [3:0]   slotValid, lat;
	logic [127:0] lineSlots, rdData, stData, d;
	logic [31:0]  ldAddr, e;
	logic [29:0]  rdAddr;
	logic [4:0]   stIdx;
	logic [1:0]   stSize;
	logic [29:0]  rdSeen[$];
	int           num_errors, checked, cyc, stalls;

	dual_simd_compute_datapath uut (.core_clk(core_clk), .srst(srst), .lineValid(lineValid),
		.slotValid(slotValid), .lineSlots(lineSlots), .ldAddr(ldAddr), .lineReady(lineReady),
		.badLine(badLine), .rdReq(rdReq), .rdAddr(rdAddr), .rdValid(rdValid), .rdData(rdData),
		.stReq(stReq), .stBlk(stBlk), .stIdx(stIdx), .stSize(stSize), .stValid(stValid),
		.stData(stData));
	load_bus_model bus (.core_clk(core_clk), .srst(srst), .rdReq(rdReq), .rdAddr(rdAddr),
		.lat(lat), .rdValid(rdValid), .rdData(rdData));

	initial
	begin
		core_clk = 0;
		forever #2.5 core_clk = ~core_clk;
	end

	always @(posedge core_clk)
	begin
		if (rdReq === 1'b1)
			rdSeen.push_back(rdAddr);
		cyc++;
		if (cyc == 4000)
		begin
			num_errors++;
			summarize;
		end
	end

	function automatic logic [31:0] mw(input logic [31:0] a);
		return {a[15:0] ^ 16'h3c5a, a[15:0]};
	endfunction
	function automatic logic [127:0] mq(input logic [31:0] a);
		return {mw(a + 3), mw(a + 2), mw(a + 1), mw(a)};
	endfunction
	function automatic logic [31:0] sl(input logic [4:0] op, input logic [1:0] blk, sz,
		input logic [4:0] dst, a, b, input logic bf);
		return {op, blk, sz, dst, a, b, bf, 7'h00};
	endfunction

	// holds the line until taken; returns at the falling edge after the taking edge
	task sendLine(input logic [3:0] sv, input logic [127:0] s, input logic [31:0] la);
		slotValid = sv;
		lineSlots = s;
		ldAddr = la;
		lineValid = 1'b1;
		stalls = 0;
		#1;
		while (lineReady !== 1'b1 && stalls < 200)
		begin
			stalls++;
			@(negedge core_clk);
			#1;
		end
		if (stalls == 200)
			num_errors++;
		@(negedge core_clk);
		lineValid = 1'b0;
	endtask

	// waits a cycle so the previous line's results have landed
	task readReg(input logic b, input logic [4:0] i, input logic [1:0] z);
		@(negedge core_clk);
		stReq = 1'b1;
		stBlk = b;
		stIdx = i;
		stSize = z;
		@(negedge core_clk);
		`CHK("stValid", 1'b1, stValid)
		d = stData;
		stReq = 1'b0;
	endtask

	task tReset;
		`CHK("ready after reset", 1'b1, lineReady)
		`CHK("badLine after reset", 1'b0, badLine)
		sendLine(4'h0, 128'h0, 32'h0);
		`CHK("empty line stalls", 0, stalls)
		readReg(1'b1, 5'd28, `SZ_QUAD);
		`CHK("cleared registers", 128'h0, d)
	endtask

	task tLoad;
		lat = 4'd3;
		rdSeen.delete();
		sendLine(4'h1, {96'h0, sl(`OP_LOAD, `BLK_X, `SZ_QUAD, 5'd0, 5'd0, 5'd0, 1'b0)}, 32'd8);
		`CHK("aligned fetch", 30'd2, rdSeen[0])
		readReg(1'b0, 5'd0, `SZ_QUAD);
		`CHK("x quad 0", mq(8), d)
		lat = 4'd1;
		sendLine(4'h1, {96'h0, sl(`OP_LOAD, `BLK_BC, `SZ_QUAD, 5'd4, 5'd0, 5'd0, 1'b0)}, 32'd16);
		readReg(1'b1, 5'd4, `SZ_QUAD);
		`CHK("y broadcast", mq(16), d)
		readReg(1'b0, 5'd7, `SZ_DUAL);
		`CHK("x broadcast pair", {64'h0, mw(19), mw(18)}, d)
		sendLine(4'h1, {96'h0, sl(`OP_LOAD, `BLK_MRG, `SZ_QUAD, 5'd12, 5'd0, 5'd0, 1'b0)}, 32'd20);
		readReg(1'b0, 5'd12, `SZ_DUAL);
		`CHK("x merged", {64'h0, mw(22), mw(20)}, d)
		readReg(1'b1, 5'd12, `SZ_DUAL);
		`CHK("y merged", {64'h0, mw(23), mw(21)}, d)
	endtask

	task tCompute;
		logic [63:0] a, b, s;
		sendLine(4'h7, {32'h0, sl(`OP_ADD16, `BLK_Y, `SZ_DUAL, 5'd10, 5'd4, 5'd6, 1'b0),
			sl(`OP_XOR, `BLK_X, `SZ_WORD, 5'd9, 5'd2, 5'd3, 1'b0),
			sl(`OP_ADD32, `BLK_X, `SZ_WORD, 5'd8, 5'd0, 5'd1, 1'b0)}, 32'h0);
		sendLine(4'h1, {96'h0, sl(`OP_ADD32, `BLK_X, `SZ_WORD, 5'd13, 5'd8, 5'd8, 1'b0)}, 32'h0);
		`CHK("dependent stalls", 1, stalls)
		sendLine(4'h3, {64'h0, sl(`OP_XOR, `BLK_X, `SZ_WORD, 5'd14, 5'd2, 5'd3, 1'b0),
			sl(`OP_ADD32, `BLK_X, `SZ_WORD, 5'd14, 5'd0, 5'd1, 1'b0)}, 32'h0);
		`CHK("independent stalls", 0, stalls)
		e = mw(8) + mw(9);
		readReg(1'b0, 5'd8, `SZ_WORD);
		`CHK("add32", {96'h0, e}, d)
		readReg(1'b0, 5'd9, `SZ_WORD);
		`CHK("xor beside add", {96'h0, mw(10) ^ mw(11)}, d)
		readReg(1'b0, 5'd13, `SZ_WORD);
		`CHK("dependent add", {96'h0, e + e}, d)
		readReg(1'b0, 5'd14, `SZ_WORD);
		`CHK("later slot wins", {96'h0, mw(10) ^ mw(11)}, d)
		a = {mw(17), mw(16)};
		b = {mw(19), mw(18)};
		for (int k = 0; k < 4; k++)
			s[16*k +: 16] = a[16*k +: 16] + b[16*k +: 16];
		readReg(1'b1, 5'd10, `SZ_DUAL);
		`CHK("add16 lanes", {64'h0, s}, d)
	endtask

	task tUnaligned;
		lat = 4'd2;
		rdSeen.delete();
		sendLine(4'h1, {96'h0, sl(`OP_LOAD, `BLK_X, `SZ_QUAD, 5'd16, 5'd0, 5'd0, 1'b1)}, 32'd13);
		`CHK("cold fetch count", 2, rdSeen.size())
		`CHK("first line", 30'd3, rdSeen[0])
		`CHK("second line", 30'd4, rdSeen[1])
		rdSeen.delete();
		sendLine(4'h1, {96'h0, sl(`OP_LOAD, `BLK_X, `SZ_QUAD, 5'd20, 5'd0, 5'd0, 1'b1)}, 32'd17);
		`CHK("warm fetch count", 1, rdSeen.size())
		`CHK("warm line", 30'd5, rdSeen[0])
		readReg(1'b0, 5'd16, `SZ_QUAD);
		`CHK("unaligned 13", mq(13), d)
		readReg(1'b0, 5'd20, `SZ_QUAD);
		`CHK("unaligned 17", mq(17), d)
	endtask

	task tBad;
		sendLine(4'h1, {96'h0, sl(`OP_LOAD, `BLK_X, `SZ_QUAD, 5'd24, 5'd0, 5'd0, 1'b0)}, 32'd2);
		`CHK("misaligned load", 1'b1, badLine)
		sendLine(4'h7, {32'h0, sl(`OP_OR, `BLK_X, `SZ_WORD, 5'd25, 5'd0, 5'd1, 1'b0),
			sl(`OP_AND, `BLK_X, `SZ_WORD, 5'd26, 5'd0, 5'd1, 1'b0),
			sl(`OP_ADD32, `BLK_X, `SZ_WORD, 5'd27, 5'd0, 5'd1, 1'b0)}, 32'h0);
		`CHK("three slots one block", 1'b1, badLine)
		@(negedge core_clk);
		`CHK("flag one cycle", 1'b0, badLine)
	endtask

	task summarize;
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial
	begin
		srst = 1'b1;
		lineValid = 1'b0;
		slotValid = 4'h0;
		lineSlots = 128'h0;
		ldAddr = 32'h0;
		stReq = 1'b0;
		stBlk = 1'b0;
		stIdx = 5'h0;
		stSize = 2'h0;
		lat = 4'h1;
		repeat (2) @(negedge core_clk);
		srst = 1'b0;
		tReset;
		tLoad;
		tCompute;
		tUnaligned;
		tBad;
		summarize;
	end
endmodule // dual_simd_compute_datapath_bench
